// *** core/rcd_map.svh ***
// Constants of the reference clock divider timebase
// Operation
// - Divide the reference clock by one, two, four or eight for the timebase.
// - Divide ratio is eight after reset until the host programs another.
// - Timebase runs at nominal 2 MHz when reference matches the ratio.
// - Fault flags latch and clear only on the divided timebase.
// - The 125 kHz carrier is derived from the timebase.
// - Chip select is active low; serial data is accepted only while low.
`ifndef RCD_MAP_SVH
`define RCD_MAP_SVH
`define RCD_SYNC_DEPTH 3
`define RCD_PIN_COUNT 4
`define RCD_PIN_REF 0
`define RCD_PIN_SCLK 1
`define RCD_PIN_SDI 2
`define RCD_PIN_SEL 3
`define RCD_FRAME_BITS 4'h8
`define RCD_CMD_WRITE_BIT 7
`define RCD_CMD_RATIO_LSB 0
`define RCD_CARRIER_HALF 3'h7
`define RCD_FAULT_WIDTH 4
`define RCD_FAULT_RESET 4'h0
`define RCD_SYNC_RESET 3'h7
`endif

// *** core/rcd_pkg.sv ***
// Types of the reference clock divider timebase
package rcd_pkg;
    typedef enum logic [1:0] {
        RCD_DIV1,
        RCD_DIV2,
        RCD_DIV4,
        RCD_DIV8
    } rcd_ratio_t;
endpackage

// *** core/rcd_timebase.sv ***
// Reference clock divider, serial ratio select, fault latch and carrier
`include "rcd_map.svh"
module rcd_timebase (
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Pins from the host
    input wire logic ref_clk_pin,
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic serial_select_n,
    // Fault sources and clear request from status logic
    input wire logic [`RCD_FAULT_WIDTH-1:0] fault_in,
    input wire logic fault_clear,
    // Timebase and derived outputs
    output logic timebase_clk,
    output logic timebase_tick,
    output logic carrier,
    output logic [`RCD_FAULT_WIDTH-1:0] fault_flags,
    output rcd_pkg::rcd_ratio_t ratio
);

    // Half-period edge count for a ratio: ratio minus one
    function automatic logic [2:0] half_limit(input rcd_pkg::rcd_ratio_t r);
        case (r)
            rcd_pkg::RCD_DIV1: half_limit = 3'h0;
            rcd_pkg::RCD_DIV2: half_limit = 3'h1;
            rcd_pkg::RCD_DIV4: half_limit = 3'h3;
            default: half_limit = 3'h7;
        endcase
    endfunction

    logic [`RCD_SYNC_DEPTH-1:0] sync_reg [`RCD_PIN_COUNT];
    logic [`RCD_PIN_COUNT-1:0] filt_reg;
    logic [`RCD_PIN_COUNT-1:0] filt_next;
    logic [2:0] edge_cnt_reg;
    logic [2:0] car_cnt_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic tb_reg;
    logic tick_reg;
    logic car_reg;
    logic clear_pend_reg;
    logic [`RCD_FAULT_WIDTH-1:0] flags_reg;
    rcd_pkg::rcd_ratio_t ratio_reg;
    rcd_pkg::rcd_ratio_t ratio_pend_reg;

    // Three-stage synchronisers; reset loads ones on every pin, data included though it idles low
    always_ff @(posedge clk) begin
        for (int i = 0; i < `RCD_PIN_COUNT; i++) begin
            if (srst) begin
                sync_reg[i] <= `RCD_SYNC_RESET;
            end else if (ce) begin
                sync_reg[i] <= {sync_reg[i][1:0], 1'b0};
            end
        end
        if (!srst && ce) begin
            sync_reg[`RCD_PIN_REF][0] <= ref_clk_pin;
            sync_reg[`RCD_PIN_SCLK][0] <= sclk_pin;
            sync_reg[`RCD_PIN_SDI][0] <= sdi_pin;
            sync_reg[`RCD_PIN_SEL][0] <= serial_select_n;
        end
    end

    // Filtered level moves only once stages two and three agree
    always_comb begin
        for (int i = 0; i < `RCD_PIN_COUNT; i++) begin
            filt_next[i] = (sync_reg[i][1] == sync_reg[i][2]) ? sync_reg[i][2] : filt_reg[i];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            filt_reg <= '1;
        end else if (ce) begin
            filt_reg <= filt_next;
        end
    end

    // Events seen on the filtered pins
    wire ref_edge = ce && (filt_next[`RCD_PIN_REF] != filt_reg[`RCD_PIN_REF]);
    wire sclk_rise = ce && filt_next[`RCD_PIN_SCLK] && !filt_reg[`RCD_PIN_SCLK];
    wire sel_low = !filt_reg[`RCD_PIN_SEL];
    wire sel_rise = ce && filt_next[`RCD_PIN_SEL] && !filt_reg[`RCD_PIN_SEL];
    wire frame_ok = (bit_cnt_reg == `RCD_FRAME_BITS) && shift_reg[`RCD_CMD_WRITE_BIT];
    wire [2:0] limit = half_limit(ratio_reg);
    wire tb_flip = ref_edge && (edge_cnt_reg == limit);
    wire tb_rise = tb_flip && !tb_reg;
    wire car_flip = tb_rise && (car_cnt_reg == `RCD_CARRIER_HALF);
    wire [`RCD_FAULT_WIDTH-1:0] flags_next =
        (clear_pend_reg ? '0 : flags_reg) | fault_in;

    // Serial receiver: bits counted only inside a low select frame
    always_ff @(posedge clk) begin
        if (srst || (ce && !sel_low)) begin
            bit_cnt_reg <= 4'h0;
        end else if (sclk_rise && sel_low && bit_cnt_reg != `RCD_FRAME_BITS) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg <= {shift_reg[6:0], filt_reg[`RCD_PIN_SDI]};
        end
    end

    // A complete write frame arms the new ratio at select release
    always_ff @(posedge clk) begin
        if (srst) begin
            ratio_pend_reg <= rcd_pkg::RCD_DIV8;
        end else if (sel_rise && frame_ok) begin
            ratio_pend_reg <= rcd_pkg::rcd_ratio_t'(shift_reg[`RCD_CMD_RATIO_LSB +: 2]);
        end
    end

    // Ratio swaps only at a timebase rising edge so no half period is cut short
    always_ff @(posedge clk) begin
        if (srst) begin
            ratio_reg <= rcd_pkg::RCD_DIV8;
        end else if (tb_rise) begin
            ratio_reg <= ratio_pend_reg;
        end
    end

    // Divider: count reference edges, flip timebase every ratio edges
    always_ff @(posedge clk) begin
        if (srst) begin
            edge_cnt_reg <= 3'h0;
            tb_reg <= 1'b0;
        end else if (ref_edge) begin
            edge_cnt_reg <= tb_flip ? 3'h0 : edge_cnt_reg + 3'h1;
            tb_reg <= tb_reg ^ tb_flip;
        end
    end

    // Carrier is timebase over sixteen: toggle every eighth tick
    always_ff @(posedge clk) begin
        if (srst) begin
            car_cnt_reg <= 3'h0;
            car_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else if (ce) begin
            tick_reg <= tb_rise;
            if (tb_rise) begin
                car_cnt_reg <= car_cnt_reg + 3'h1;
                car_reg <= car_reg ^ car_flip;
            end
        end
    end

    // Faults latch on the tick; a clear waits for it and a new fault still wins
    always_ff @(posedge clk) begin
        if (srst) begin
            flags_reg <= `RCD_FAULT_RESET;
            clear_pend_reg <= 1'b0;
        end else if (ce) begin
            if (tb_rise) begin
                flags_reg <= flags_next;
                clear_pend_reg <= fault_clear;
            end else if (fault_clear) begin
                clear_pend_reg <= 1'b1;
            end
        end
    end

    assign timebase_clk = tb_reg;
    assign timebase_tick = tick_reg;
    assign carrier = car_reg;
    assign fault_flags = flags_reg;
    assign ratio = ratio_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_ratio_after_reset: assert property (
        $past(srst) |-> ratio_reg == rcd_pkg::RCD_DIV8)
        else $error("ratio not eight after reset");
    a_tb_on_ref: assert property (
        !$past(srst) && $changed(tb_reg) |-> $past(ref_edge))
        else $error("timebase moved without reference edge");
    a_tb_half_count: assert property (
        ref_edge && edge_cnt_reg == limit |=> $changed(tb_reg) && edge_cnt_reg == 3'h0)
        else $error("timebase half period wrong length");
    a_fault_on_tick: assert property (
        !$past(srst) && $changed(flags_reg) |-> $past(tb_rise))
        else $error("fault flags changed off the timebase");
    a_carrier_div: assert property (
        !$past(srst) && $changed(car_reg) |-> $past(tb_rise) && car_cnt_reg == 3'h0)
        else $error("carrier toggled at wrong tick");
    a_select_frame: assert property (
        ce && !sel_low |=> bit_cnt_reg == 4'h0)
        else $error("bits counted with select high");
    a_ratio_glitch_free: assert property (
        !$past(srst) && $changed(ratio_reg) |-> tb_reg && !$past(tb_reg))
        else $error("ratio changed mid period");

    // Tick is the registered copy of the timebase rise, one cycle wide
    a_tick_after_rise: assert property (
        tb_rise |=> tick_reg)
        else $error("tick missing after timebase rise");

    a_tick_single: assert property (
        tick_reg |=> !tick_reg)
        else $error("tick wider than one cycle");

    // Counter never runs past the active ratio, even across a swap
    a_count_in_range: assert property (
        edge_cnt_reg <= limit)
        else $error("edge count beyond ratio limit");

    // Set wins: a fault present at the rise is always kept
    a_fault_set_wins: assert property (
        tb_rise |=> (flags_reg & $past(fault_in)) == $past(fault_in))
        else $error("fault lost at timebase rise");

    // A pending clear leaves only the faults still present
    a_fault_clear_done: assert property (
        tb_rise && clear_pend_reg |=> flags_reg == $past(fault_in))
        else $error("pending clear not applied");

    // Ratio never moves between timebase rises
    a_ratio_stable: assert property (
        !tb_rise |=> $stable(ratio_reg))
        else $error("ratio moved off a timebase rise");

    c_ratio_write: cover property (sel_rise && frame_ok);
    c_carrier_flip: cover property (car_flip);
    c_fault_latch: cover property (tb_rise && fault_clear && |fault_in);
    c_ratio_one: cover property (tb_rise && ratio_reg == rcd_pkg::RCD_DIV1);

endmodule

// *** sim/rcd_host_model.sv ***
// Host model: reference clock and serial ratio writes
module rcd_host_model (
    // Clock
    input wire logic clk,
    // Pins to the device
    output logic ref_clk_pin,
    output logic sclk_pin,
    output logic sdi_pin,
    output logic serial_select_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int ref_cnt = 0;
    // Clock and select pins idle high, data idles low; the reference starts parked high
    initial begin
        ref_clk_pin = 1'b1;
        sclk_pin = 1'b1;
        sdi_pin = 1'b0;
        serial_select_n = 1'b1;
    end
    // Reference half period of 4 clk, never stopped after a write
    always @(posedge clk) begin
        ref_cnt <= (ref_cnt == 3) ? 0 : ref_cnt + 1;
        if (ref_cnt == 3) ref_clk_pin <= ~ref_clk_pin;
    end
    // One byte MSB first; framed=0 leaves select high so it must be ignored
    task automatic send_byte(input logic [7:0] data, input logic framed);
        serial_select_n <= ~framed;
        repeat (5) @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            sdi_pin <= data[i];
            sclk_pin <= 1'b0;
            repeat (5) @(posedge clk);
            sclk_pin <= 1'b1;
            repeat (5) @(posedge clk);
        end
        serial_select_n <= 1'b1;
        sdi_pin <= ~data[0]; // Released data no longer shows the last bit
        repeat (8) @(posedge clk);
    endtask
endmodule

// *** sim/ref_clock_divider_timebase_test.sv ***
// Self-checking bench for the reference clock divider timebase
`include "rcd_map.svh"
module ref_clock_divider_timebase_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic fault_clear = 1'b0;
    logic [`RCD_FAULT_WIDTH-1:0] fault_in = 4'h0;
    logic [`RCD_FAULT_WIDTH-1:0] fault_flags;
    logic [`RCD_FAULT_WIDTH-1:0] r;
    logic ref_clk_pin, sclk_pin, sdi_pin, serial_select_n;
    logic timebase_clk, timebase_tick, carrier, c0;
    logic [31:0] rr;
    rcd_pkg::rcd_ratio_t ratio;
    int num_errors = 0;
    int comparisons = 0;
    int seed = 80939;
    int since = 0;
    int period_q[$];

    rcd_host_model host (.clk(clk), .ref_clk_pin(ref_clk_pin), .sclk_pin(sclk_pin),
        .sdi_pin(sdi_pin), .serial_select_n(serial_select_n));
    rcd_timebase dut (.clk(clk), .srst(srst), .ce(1'b1), .ref_clk_pin(ref_clk_pin),
        .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .serial_select_n(serial_select_n),
        .fault_in(fault_in), .fault_clear(fault_clear), .timebase_clk(timebase_clk),
        .timebase_tick(timebase_tick), .carrier(carrier), .fault_flags(fault_flags),
        .ratio(ratio));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check_bits(input string what, input logic [3:0] exp, input logic [3:0] seen);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_count(input string what, input int exp, input int seen);
        comparisons++;
        if (seen != exp) begin
            num_errors++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, seen);
        end
    endtask

    // Timebase period between ticks, compared with the oldest note
    always @(posedge clk) begin
        since <= since + 1;
        if (timebase_tick === 1'b1) begin
            since <= 1;
            if (period_q.size() > 0) check_count("period", period_q.pop_front(), since);
        end
    end

    task automatic ticks(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            while (timebase_tick !== 1'b1) @(posedge clk);
        end
    endtask

    // Notes two whole periods at 8 clk per reference period times the ratio
    task automatic note_periods(input int code);
        @(negedge clk);
        period_q.push_back(8 << code);
        period_q.push_back(8 << code);
        ticks(3);
    endtask

    task automatic pulse_clear();
        fault_clear <= 1'b1;
        @(posedge clk);
        fault_clear <= 1'b0;
    endtask

    task automatic conclude();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        fork
            begin
                #400000;
                num_errors++;
                conclude();
            end
        join_none
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check_bits("reset ratio", 4'h3, {2'b00, ratio});
        ticks(1);
        note_periods(3);
        c0 = carrier;
        ticks(8);
        check_bits("carrier", {3'h0, ~c0}, {3'h0, carrier});
        ticks(8);
        check_bits("carrier", {3'h0, c0}, {3'h0, carrier});
        for (int code = 0; code < 4; code++) begin
            rr = $random(seed);
            host.send_byte({1'b1, rr[6:2], 2'(code)}, 1'b1);
            ticks(3);
            check_bits("ratio", 4'(code), {2'b00, ratio});
            note_periods(code);
        end
        host.send_byte(8'h01, 1'b1);
        host.send_byte(8'h82, 1'b0);
        ticks(3);
        check_bits("refused ratio", 4'h3, {2'b00, ratio});
        rr = $random(seed);
        r = rr[3:0] | 4'h1;
        fault_in <= r;
        pulse_clear();
        ticks(2);
        check_bits("flags", r, fault_flags);
        fault_in <= 4'h0;
        ticks(2);
        check_bits("held flags", r, fault_flags);
        pulse_clear();
        ticks(2);
        check_bits("cleared flags", 4'h0, fault_flags);
        srst <= 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check_bits("second reset ratio", 4'h3, {2'b00, ratio});
        conclude();
    end
endmodule
